/* dv/tb.sv */
// Purpose: self-checking bench for the clock enable and routing block
// Assumes: zero-wait apb slave, clock ticks are one-cycle enables
// Notes: corner values first, then random values from a fixed seed
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
  fails++; $display("MISMATCH %s exp=%0h got=%0h", nm, ex, gt); end end
module tb;
  import ccr_pkg::*;
  // clock, reset and apb
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [CCR_PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  // clock sources, controls and routed ticks
  logic ext_clk_tick, pll_clk_tick, pll_lock;
  logic pll_power_on, pll_clk_enable, oscillator_enable;
  logic [8*CCR_PLL_REGS-1:0] pll_config;
  logic main_source_select, main_tick, master_tick, core_tick;
  logic reg_write_allow;
  // two-wire bus lines
  logic spi_mode, scl_in, sda_in, scl_filt, sda_filt;
  // bench state
  int fails, tests_run;
  logic [31:0] rd;
  logic err;
  logic [7:0] v;
  logic [7:0] pb [5];
  logic [7:0] corner [6] = '{8'h00, 8'h01, 8'h81, 8'h89, 8'h8F, 8'h09};

  ccr_top DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_clk_tick(ext_clk_tick), .pll_clk_tick(pll_clk_tick),
    .pll_lock(pll_lock), .pll_power_on(pll_power_on),
    .pll_clk_enable(pll_clk_enable), .pll_config(pll_config),
    .oscillator_enable(oscillator_enable),
    .main_source_select(main_source_select), .main_tick(main_tick),
    .master_tick(master_tick), .core_tick(core_tick),
    .reg_write_allow(reg_write_allow), .spi_mode(spi_mode),
    .scl_in(scl_in), .sda_in(sda_in), .scl_filt(scl_filt),
    .sda_filt(sda_filt));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // expected main ticks: gated by main enable, pll path also by pll enable
  function automatic int exp_main(logic [7:0] r, int n);
    return (r[0] && (!r[3] || r[7])) ? n : 0;
  endfunction

  // expected divided ticks over an even number of main ticks
  function automatic int exp_div(int m, logic one);
    return one ? m : m / 2;
  endfunction

  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // write the control word, read it back, check the static outputs
  task automatic chk_reg(input logic [7:0] r);
    apb(1'b1, 8'h00, {24'h0, r}, 4'hF);
    `CHK("write err", 1'b0, err)
    apb(1'b0, 8'h00, 32'h0, 4'hF);
    `CHK("readback", {24'h0, r}, rd)
    @(negedge clk);
    `CHK("pll_power_on", r[7], pll_power_on)
    `CHK("pll_clk_enable", r[7] & r[0], pll_clk_enable)
    `CHK("oscillator_enable", ~r[4], oscillator_enable)
    `CHK("main_source_select", r[3], main_source_select)
    `CHK("reg_write_allow", r[0], reg_write_allow)
    @(posedge clk);
  endtask

  // 16 ticks on the selected source, noise on the other one
  task automatic run_ticks(input logic [7:0] r);
    int m, ms, cr;
    m = 0;
    ms = 0;
    cr = 0;
    for (int i = 0; i < 32; i++) begin
      pll_clk_tick <= r[3] ? i[0] : 1'($urandom);
      ext_clk_tick <= r[3] ? 1'($urandom) : i[0];
      @(negedge clk);
      m += int'(main_tick === 1'b1);
      ms += int'(master_tick === 1'b1);
      cr += int'(core_tick === 1'b1);
      @(posedge clk);
    end
    pll_clk_tick <= 1'b0;
    ext_clk_tick <= 1'b0;
    `CHK("main ticks", exp_main(r, 16), m)
    `CHK("master ticks", exp_div(exp_main(r, 16), r[1]), ms)
    `CHK("core ticks", exp_div(exp_main(r, 16), r[2]), cr)
  endtask

  // low pulse of len cycles on both lines; was it passed on?
  task automatic glitch(input int len, input logic byp);
    logic ss, sd;
    ss = 1'b0;
    sd = 1'b0;
    for (int i = 0; i < len + 10; i++) begin
      scl_in <= (i >= len);
      sda_in <= (i >= len);
      @(negedge clk);
      ss |= (scl_filt === 1'b0);
      sd |= (sda_filt === 1'b0);
      @(posedge clk);
    end
    `CHK("scl pulse", byp || len >= CCR_FILT_CYC, ss)
    `CHK("sda pulse", byp || len >= CCR_FILT_CYC, sd)
  endtask

  // counts and verdict, the one place the run ends
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {ext_clk_tick, pll_clk_tick, pll_lock, spi_mode} = '0;
    scl_in = 1'b1;
    sda_in = 1'b1;
    reset = 1'b1;
    fails = 0;
    tests_run = 0;
    void'($urandom(42));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHK("rst pll_power_on", 1'b0, pll_power_on)
    `CHK("rst osc", 1'b1, oscillator_enable)
    `CHK("rst allow", 1'b0, reg_write_allow)
    `CHK("rst scl_filt", 1'b1, scl_filt)
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0, 4'hF);
    `CHK("rst value", {24'h0, CCR_CLK_RESET}, rd)
    $display("test reset done");
    // pll set up first with the main clock off, then lock comes up
    apb(1'b1, 8'h00, 32'h0, 4'hF);
    for (int k = 0; k < 5; k++) begin
      pb[k] = 8'($urandom);
      apb(1'b1, 8'((k + 1) * 4), {24'h0, pb[k]}, 4'hF);
    end
    for (int k = 0; k < 5; k++)
      `CHK("pll byte", pb[k], pll_config[8*k +: 8])
    pll_lock <= 1'b1;
    apb(1'b1, 8'h18, 32'h0, 4'hF);
    `CHK("status write err", 1'b1, err)
    apb(1'b0, 8'h18, 32'h0, 4'hF);
    `CHK("lock read", 32'h1, rd)
    apb(1'b0, 8'h1C, 32'h0, 4'hF);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, 8'h01, 32'hFF, 4'hF);
    `CHK("misaligned err", 1'b1, err)
    apb(1'b1, 8'h00, 32'hFF, 4'h0);
    apb(1'b0, 8'h00, 32'h0, 4'hF);
    `CHK("no strobe write", 32'h0, rd)
    $display("test map done");
    // corner words, then random ones; pll source only now, after lock
    for (int i = 0; i < 14; i++) begin
      v = (i < 6) ? corner[i] : 8'($urandom);
      chk_reg(v);
      run_ticks(v);
    end
    // flip only the reserved bit: the clocks must not notice
    chk_reg(v ^ 8'h40);
    run_ticks(v ^ 8'h40);
    $display("test routing done");
    // reset in mid-run must clear a written control word
    apb(1'b1, 8'h00, 32'hFF, 4'hF);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHK("mid rst pll_power_on", 1'b0, pll_power_on)
    `CHK("mid rst allow", 1'b0, reg_write_allow)
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0, 4'hF);
    `CHK("mid rst value", {24'h0, CCR_CLK_RESET}, rd)
    $display("test mid reset done");
    // filter modes: control bit five and interface mode, all four pairs
    for (int md = 0; md < 4; md++) begin
      apb(1'b1, 8'h00, {26'h0, md[0], 5'h0}, 4'hF);
      spi_mode <= md[1];
      foreach (corner[j]) if (j < 4)
        glitch(j == 0 ? 1 : j == 1 ? 4 : j == 2 ? 5 : 8, md[0] | md[1]);
    end
    $display("test filter done");
    print_verdict();
  end

  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule

/* hdl/ccr_pkg.sv */
// Purpose: constants for the codec clock enable and routing block
// Assumes: APB word per register, byte address is four times the index
// Notes: bit positions, reset values and filter timing live here
package ccr_pkg;
  // register indices; byte address = index * 4
  localparam logic [5:0] CCR_IDX_CLK = 6'h00;
  localparam logic [5:0] CCR_IDX_PLL_FIRST = 6'h01;
  localparam logic [5:0] CCR_IDX_PLL_LAST = 6'h05;
  localparam logic [5:0] CCR_IDX_STATUS = 6'h06;
  localparam int CCR_PLL_REGS = 5;
  localparam int CCR_PADDR_W = 8;
  // clock_enable_routing field positions
  localparam int CCR_BIT_PLL_EN = 7;
  localparam int CCR_BIT_RSVD = 6;
  localparam int CCR_BIT_FILT_OFF = 5;
  localparam int CCR_BIT_OSC_OFF = 4;
  localparam int CCR_BIT_SRC = 3;
  localparam int CCR_BIT_CDIV = 2;
  localparam int CCR_BIT_MDIV = 1;
  localparam int CCR_BIT_MAIN_ON = 0;
  // pll_status_reg lock flag position
  localparam int CCR_BIT_LOCK = 0;
  // reset values
  localparam logic [7:0] CCR_CLK_RESET = 8'h00;
  localparam logic [7:0] CCR_PLL_RESET = 8'h00;
  // spike filter timing: least time, rounded up to whole cycles
  localparam int CCR_FILT_NS = 50;
  localparam int CCR_CLK_MHZ = 100;
  localparam int CCR_FILT_CYC = (CCR_FILT_NS * CCR_CLK_MHZ + 999) / 1000;
endpackage

/* hdl/ccr_spike_filter.sv */
// Purpose: suppress short spikes on one two-wire bus input
// Assumes: raw is synchronous to clk
// Notes: a level must hold CYC cycles before it is passed on
`timescale 1ns/1ps
module ccr_spike_filter
  import ccr_pkg::*;
#(
  parameter int CYC = CCR_FILT_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // line
  input wire logic raw,
  input wire logic enable,
  output logic filt
);
  // whole state of the filter
  typedef struct packed {
    logic level;     // filtered level
    logic [7:0] cnt; // cycles the raw level has differed
  } ccr_filt_s;

  ccr_filt_s st;
  ccr_filt_s next_st;

  // count disagreement; a shorter spike resets the count
  always_comb begin
    next_st = st;
    if (!enable) begin
      next_st.level = raw; // bypass: follow one cycle late
      next_st.cnt = '0;
    end else if (raw == st.level) begin
      next_st.cnt = '0;
    end else if (st.cnt == 8'(CYC - 1)) begin
      next_st.level = raw; // RULE4
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  // idle bus level is high, so the filter starts there
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{level: 1'b1, cnt: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign filt = st.level;

  // while filtering, a change needs the new level held five cycles
  property p_filt_hold;
    @(posedge clk) disable iff (reset)
      $changed(filt) && $past(enable) && $past(enable, 5) |->
        $past(raw, 1) == filt && $past(raw, 5) == filt;
  endproperty
  a_filt_hold: assert property (p_filt_hold) // RULE4
    else $error("filter passed a level held too briefly");
endmodule

/* hdl/ccr_tick_div.sv */
// Purpose: divide an enable pulse stream by two or pass it through
// Assumes: tick_in is a one-cycle enable in the clk domain
// Notes: output is combinational so it lines up with its source tick
`timescale 1ns/1ps
module ccr_tick_div
  import ccr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // tick path
  input wire logic tick_in,
  input wire logic div_by_one,
  output logic tick_out
);
  // whole state of the divider
  typedef struct packed {
    logic phase; // high on every second input tick
  } ccr_div_s;

  ccr_div_s st;
  ccr_div_s next_st;

  // phase flips on each input tick
  always_comb begin
    next_st = st;
    if (tick_in) begin
      next_st.phase = ~st.phase;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // divide by 2 keeps only the phase-high ticks
  assign tick_out = tick_in & (div_by_one | st.phase);

  // in divide-by-2, input ticks alternate between dropped and passed
  property p_div_two;
    @(posedge clk) disable iff (reset)
      tick_in && !div_by_one |=> st.phase == !$past(tick_out);
  endproperty
  a_div_two: assert property (p_div_two) // RULE8
    else $error("divider passed a tick in the wrong phase");
endmodule

/* hdl/ccr_top.sv */
// Purpose: clock enable and routing control register with APB access
// Assumes: clock ticks arrive as one-cycle enables on clk
// Notes: zero-wait APB; read data is latched in the setup cycle
// Operation
// RULE1 - pll enable bit powers pll up or down
// RULE2 - software configures pll before enabling it
// RULE3 - pll clock runs only with pll and main enabled
// RULE4 - 50 ns spike filter on by default
// RULE5 - spi mode always bypasses the spike filter
// RULE6 - source bit picks external pin or pll
// RULE7 - software selects pll only after lock
// RULE8 - core divider bit selects divide two or one
// RULE9 - software sets core clock to 12.288 MHz
// RULE10 - register at offset zero resets to zero
// RULE11 - main enable off blocks other register writes
// RULE12 - master divider bit selects divide two or one
// RULE13 - software keeps main enable off until lock
// RULE14 - reserved bit six stored, no clock effect
`timescale 1ns/1ps
module ccr_top
  import ccr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CCR_PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // clock sources and pll status
  input wire logic ext_clk_tick,
  input wire logic pll_clk_tick,
  input wire logic pll_lock,
  // pll controls
  output logic pll_power_on,
  output logic pll_clk_enable,
  output logic [8*CCR_PLL_REGS-1:0] pll_config,
  // clock routing
  output logic oscillator_enable,
  output logic main_source_select,
  output logic main_tick,
  output logic master_tick,
  output logic core_tick,
  // write gate for the rest of the register map
  output logic reg_write_allow,
  // two-wire control bus inputs
  input wire logic spi_mode,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_filt,
  output logic sda_filt
);
  // whole state of the block
  typedef struct packed {
    logic [7:0] clock_enable_routing;           // main control register
    logic [CCR_PLL_REGS-1:0][7:0] pll_cfg;      // pll setting registers
    logic [7:0] rdata;                          // read data for access
  } ccr_top_s;

  ccr_top_s st;
  ccr_top_s next_st;

  // decoded field views
  logic glitch_filter_off;
  logic oscillator_off;
  logic core_divider_select;
  logic master_divider_select;
  logic main_clock_on;
  logic pll_en;

  // bus phase strobes
  logic setup_ph;
  logic access_ph;
  logic wr_ok;
  logic [5:0] idx;
  logic mapped;

  // one decode used for both read and write paths
  function automatic logic ccr_mapped(input logic [CCR_PADDR_W-1:0] a);
    ccr_mapped = (a[1:0] == 2'h0) && (a[7:2] <= CCR_IDX_STATUS);
  endfunction

  // register contents read back at an index
  function automatic logic [7:0] ccr_read(input logic [5:0] i,
                                          input ccr_top_s s,
                                          input logic lock);
    logic [7:0] v;
    v = 8'h00;
    if (i == CCR_IDX_CLK) begin
      v = s.clock_enable_routing;
    end else if (i >= CCR_IDX_PLL_FIRST && i <= CCR_IDX_PLL_LAST) begin
      v = s.pll_cfg[3'(i - CCR_IDX_PLL_FIRST)];
    end else if (i == CCR_IDX_STATUS) begin
      v[CCR_BIT_LOCK] = lock;
    end
    ccr_read = v;
  endfunction

  assign idx = paddr[7:2];
  assign mapped = ccr_mapped(paddr);
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  // status register is read only; byte lane 0 carries the data
  assign wr_ok = access_ph & pwrite & mapped & pstrb[0] &
                 (idx != CCR_IDX_STATUS);

  // register updates and read capture
  always_comb begin
    next_st = st;
    if (setup_ph) begin
      next_st.rdata = ccr_read(idx, st, pll_lock);
    end
    // clock and pll registers stay writable with main clock off
    if (wr_ok) begin // RULE11
      if (idx == CCR_IDX_CLK) begin
        next_st.clock_enable_routing = pwdata[7:0]; // RULE14
      end else begin
        next_st.pll_cfg[3'(idx - CCR_IDX_PLL_FIRST)] = pwdata[7:0];
      end
    end
  end

  // synchronous reset clears every bit
  always_ff @(posedge clk) begin
    if (reset) begin
      st.clock_enable_routing <= CCR_CLK_RESET; // RULE10
      st.pll_cfg <= {CCR_PLL_REGS{CCR_PLL_RESET}};
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // zero wait states; unmapped or read-only writes answer with an error
  assign pready = 1'b1;
  assign prdata = {24'h000000, st.rdata};
  assign pslverr = access_ph & (~mapped |
                   (pwrite & (idx == CCR_IDX_STATUS)));

  // field views; bit 6 is stored but steers nothing
  assign pll_en = st.clock_enable_routing[CCR_BIT_PLL_EN];
  assign glitch_filter_off = st.clock_enable_routing[CCR_BIT_FILT_OFF];
  assign oscillator_off = st.clock_enable_routing[CCR_BIT_OSC_OFF];
  assign main_source_select = st.clock_enable_routing[CCR_BIT_SRC];
  assign core_divider_select = st.clock_enable_routing[CCR_BIT_CDIV];
  assign master_divider_select = st.clock_enable_routing[CCR_BIT_MDIV];
  assign main_clock_on = st.clock_enable_routing[CCR_BIT_MAIN_ON];

  // pll power and output gate
  assign pll_power_on = pll_en; // RULE1
  assign pll_clk_enable = pll_en & main_clock_on; // RULE3
  assign pll_config = st.pll_cfg;
  assign oscillator_enable = ~oscillator_off;
  // other registers of the device accept writes only with main clock on
  assign reg_write_allow = main_clock_on; // RULE11

  // main clock mux; pll ticks are dead unless its output is enabled
  assign main_tick = main_clock_on & (main_source_select ?
                     (pll_clk_tick & pll_clk_enable) : ext_clk_tick); // RULE6

  // master clock for all logic but the core
  ccr_tick_div u_master_div (
    .clk(clk),
    .reset(reset),
    .tick_in(main_tick),
    .div_by_one(master_divider_select),
    .tick_out(master_tick)
  ); // RULE12

  // core-only clock
  ccr_tick_div u_core_div (
    .clk(clk),
    .reset(reset),
    .tick_in(main_tick),
    .div_by_one(core_divider_select),
    .tick_out(core_tick)
  ); // RULE8

  // spi mode overrides the disable bit and bypasses both lines
  logic filt_enable;
  logic [1:0] bus_raw;
  logic [1:0] bus_filt;
  assign filt_enable = ~glitch_filter_off & ~spi_mode; // RULE4 RULE5
  assign bus_raw = {sda_in, scl_in};
  assign scl_filt = bus_filt[0];
  assign sda_filt = bus_filt[1];

  // one filter per bus line
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      ccr_spike_filter #(.CYC(CCR_FILT_CYC)) u_filt (
        .clk(clk),
        .reset(reset),
        .raw(bus_raw[g]),
        .enable(filt_enable),
        .filt(bus_filt[g])
      );
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // a completed write to the clock register
  sequence s_wr_clk;
    wr_ok && idx == CCR_IDX_CLK;
  endsequence

  property p_pll_power;
    s_wr_clk |=> pll_power_on == $past(pwdata[CCR_BIT_PLL_EN]);
  endproperty
  a_pll_power: assert property (p_pll_power) // RULE1
    else $error("pll power does not follow the written enable bit");

  property p_pll_gate;
    main_tick && main_source_select |-> pll_clk_enable && pll_clk_tick;
  endproperty
  a_pll_gate: assert property (p_pll_gate) // RULE3
    else $error("pll tick reached main clock while gated");

  property p_spi_bypass;
    spi_mode && $past(spi_mode) |-> scl_filt == $past(scl_in) &&
                                    sda_filt == $past(sda_in);
  endproperty
  a_spi_bypass: assert property (p_spi_bypass) // RULE5
    else $error("spike filter active in spi mode");

  property p_src_mux;
    main_tick |-> (main_source_select ? pll_clk_tick : ext_clk_tick);
  endproperty
  a_src_mux: assert property (p_src_mux) // RULE6
    else $error("main tick from the wrong source");

  property p_core_src;
    core_tick |-> main_tick && (core_divider_select || !$past(core_tick));
  endproperty
  a_core_src: assert property (p_core_src) // RULE8
    else $error("core tick not derived from main tick");

  property p_master_src;
    master_tick |-> main_tick;
  endproperty
  a_master_src: assert property (p_master_src) // RULE12
    else $error("master tick not derived from main tick");

  property p_reset_val;
    @(posedge clk) $past(reset) && !reset |->
      !pll_power_on && !main_source_select && oscillator_enable &&
      !reg_write_allow && filt_enable == !spi_mode;
  endproperty
  a_reset_val: assert property (p_reset_val) // RULE10
    else $error("clock register not cleared by reset");

  property p_write_gate;
    s_wr_clk ##1 1'b1 |-> reg_write_allow == $past(pwdata[0]);
  endproperty
  a_write_gate: assert property (p_write_gate) // RULE11
    else $error("write gate does not follow main clock enable");

  property p_rsvd_bit;
    s_wr_clk ##0 (pwdata[7:0] ^ st.clock_enable_routing) == 8'h40 |=>
      $stable(pll_power_on) && $stable(main_source_select) &&
      $stable(reg_write_allow) && $stable(oscillator_enable) &&
      st.clock_enable_routing[CCR_BIT_RSVD] == $past(pwdata[6]);
  endproperty
  a_rsvd_bit: assert property (p_rsvd_bit) // RULE14
    else $error("reserved bit changed clock behaviour or was not stored");

  // a completed write to one pll setting register
  sequence s_wr_pll;
    wr_ok && idx != CCR_IDX_CLK;
  endsequence

  // pll settings land even while the main clock is off
  property p_pll_cfg;
    s_wr_pll |=> st.pll_cfg[3'($past(idx) - CCR_IDX_PLL_FIRST)] ==
                 $past(pwdata[7:0]);
  endproperty
  a_pll_cfg: assert property (p_pll_cfg) // RULE11
    else $error("pll setting write did not land");

  // refused or unstrobed writes leave the control register alone
  property p_refused;
    access_ph && pwrite && !wr_ok |=> $stable(st.clock_enable_routing);
  endproperty
  a_refused: assert property (p_refused) // RULE10
    else $error("refused write changed the clock register");

  // divide by one passes every main tick to the master clock
  property p_master_div;
    main_tick && master_divider_select |-> master_tick;
  endproperty
  a_master_div: assert property (p_master_div) // RULE12
    else $error("master divider dropped a tick in divide by one");

  // same for the core clock
  property p_core_div;
    main_tick && core_divider_select |-> core_tick;
  endproperty
  a_core_div: assert property (p_core_div) // RULE8
    else $error("core divider dropped a tick in divide by one");
endmodule
